/* core/prescaled_reload_timer_waveform.sv */
/*
  Eight-bit reload timer with eight-bit prescaler, timer and waveform
  modes, AHB-Lite register slave. Assumes one hclk domain; the
  companion underflow and port latch come from logic on hclk.
*/
// The AHB-Lite register port was chosen for this implementation.
// Operation
// - Primary reload resets to all ones and returns there on forced halt.
// - Count source: undivided, half, eighth clock or companion underflow.
// - Source code 00 undivided, 01 eighth, 10 companion, 11 half.
// - Timer mode decrements, reloads primary on underflow, keeps counting.
// - Timer underflow rate is source over (prescaler+1)(primary+1).
// - Writing one to the run request starts counting in both modes.
// - Writing zero to run request or one to forced halt stops counting.
// - Forced halt resets reloads, counters, run request and active flags.
// - Timer mode raises an interrupt request on every timer underflow.
// - Prescaler and primary addresses read the live counters.
// - Writes while stopped load both reload register and counter.
// - Timer mode running: target bit 0 loads both, 1 reload only.
// - Counter loads happen on source tick or prescaler underflow only.
// - Waveform mode toggles output per underflow, alternating reloads.
// - Waveform mode starts with the primary interval.
// - Intervals last (pre+1)(primary+1) and (pre+1)(secondary+1) ticks.
// - Waveform interrupt follows secondary underflow with output change.
// - Waveform writes hit reloads only; prescaler used at its next underflow, primary and secondary from the primary interval after a primary write.
// - Waveform primary address reads the running count in any interval.
// - Polarity bit picks primary and secondary output levels.
// - Polarity 0: high primary, low secondary, low stopped; 1 inverse.
// - Output source latched at start or interrupt, from next primary.
// - One-shot register unused here; secondary unused in timer mode.
`include "timer_rb_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module prescaled_reload_timer_waveform
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [11:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 companion_uf,
  input  wire logic                 shared_port_latch,
  output logic                      pulse_out_pin,
  output logic                      pulse_out_oe,
  output logic                      timer_irq
);
  import timer_rb_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t s_r;
  state_t s_nxt;
  logic   tick;
  logic   pre_uf;
  logic   tmr_uf;
  logic   take;
  logic   wave;
  logic   hold;
  logic [7:0] wd;
  logic [7:0] rd;

  // Reset image of the whole state record; one constant keeps the
  // asynchronous reset branch free of anything but a constant
  localparam state_t RESET_STATE = '{
    wr_q:     1'b0,
    addr_q:   10'h000,
    rdata:    8'h00,
    div:      `RST_DIVIDER,
    run:      1'b0,
    active:   1'b0,
    mode:     MODE_TIMER,
    wtgt:     1'b0,
    src:      SRC_UNDIVIDED,
    cut:      1'b0,
    ioc:      4'h0,
    pre_rld:  `RST_RELOAD,
    pre_cnt:  `RST_RELOAD,
    sec_rld:  `RST_RELOAD,
    pri_rld:  `RST_RELOAD,
    tmr_cnt:  `RST_RELOAD,
    pre_pend: 1'b0,
    tmr_pend: 1'b0,
    phase:    PH_PRIMARY,
    pri_use:  `RST_RELOAD,
    sec_use:  `RST_RELOAD,
    pri_new:  1'b0,
    osel_act: 1'b0,
    pin:      1'b0,
    irq:      1'b0
  };

  // Read mux on the address phase
  // A read right after a write to the same register still shows the old value
  always_comb
  begin
    unique case (haddr[11:2])
      `IDX_TIMER_CONTROL:
        rd = {6'h00, s_r.active, s_r.run};
      `IDX_OUTPUT_CONTROL:
        rd = {4'h0, s_r.ioc};
      `IDX_TIMER_MODE_CFG:
        rd = {s_r.cut, 1'b0, s_r.src, s_r.wtgt, 1'b0, s_r.mode};
      `IDX_PRESCALER_RELOAD:
        rd = s_r.pre_cnt;
      `IDX_PRIMARY_RELOAD:
        rd = s_r.tmr_cnt;
      default:
        rd = 8'h00;
    endcase
  end

  // Next-state logic: bus, divider, counting, then register writes
  always_comb
  begin
    s_nxt  = s_r;
    wd     = hwdata[7:0];
    pre_uf = 1'b0;
    tmr_uf = 1'b0;
    wave   = (s_r.mode == MODE_WAVE);
    take   = hsel && htrans[1] && hready;
    s_nxt.irq    = 1'b0;
    s_nxt.wr_q   = take && hwrite;
    s_nxt.addr_q = haddr[11:2];
    if (take && !hwrite)
    begin
      s_nxt.rdata = rd;
    end

    // Count source selection
    // Free-running divider gives half and eighth rates; cutoff gates every tick
    s_nxt.div = s_r.div - 3'h1;
    unique case (s_r.src)
      SRC_UNDIVIDED: tick = 1'b1;
      SRC_EIGHTH:    tick = (s_r.div == 3'h0);
      SRC_COMPANION: tick = companion_uf;
      SRC_HALF:      tick = s_r.div[0];
    endcase
    hold = s_r.cut;
    tick = tick && !hold;

    // Prescaler stage
    // A pending write loads on a tick instead of a decrement, never at once
    if (s_r.active && tick)
    begin
      if (s_r.pre_pend)
      begin
        s_nxt.pre_cnt  = s_r.pre_rld;
        s_nxt.pre_pend = 1'b0;
      end
      else if (s_r.pre_cnt == 8'h00)
      begin
        s_nxt.pre_cnt = s_r.pre_rld;
        pre_uf = 1'b1;
      end
      else
      begin
        s_nxt.pre_cnt = s_r.pre_cnt - 8'h01;
      end
    end

    // Timer stage counts prescaler underflows
    // A counter at zero underflows on its next tick, so n spans n+1 ticks
    if (pre_uf)
    begin
      if (s_r.tmr_pend)
      begin
        s_nxt.tmr_cnt  = s_r.pri_rld;
        s_nxt.tmr_pend = 1'b0;
      end
      else if (s_r.tmr_cnt == 8'h00)
      begin
        tmr_uf = 1'b1;
      end
      else
      begin
        s_nxt.tmr_cnt = s_r.tmr_cnt - 8'h01;
      end
    end

    // Underflow handling per mode
    // Interrupt is registered with the pin so both change on one edge
    if (tmr_uf)
    begin
      if (wave)
      begin
        if (s_r.phase == PH_PRIMARY)
        begin
          s_nxt.tmr_cnt = s_r.sec_use;
          s_nxt.phase   = PH_SECONDARY;
        end
        else
        begin
          s_nxt.phase    = PH_PRIMARY;
          s_nxt.irq      = 1'b1;
          s_nxt.osel_act = s_r.ioc[`BIT_OUTPUT_SOURCE];
          if (s_r.pri_new)
          begin
            s_nxt.pri_use = s_r.pri_rld;
            s_nxt.sec_use = s_r.sec_rld;
            s_nxt.tmr_cnt = s_r.pri_rld;
            s_nxt.pri_new = 1'b0;
          end
          else
          begin
            s_nxt.tmr_cnt = s_r.pri_use;
          end
        end
      end
      else
      begin
        s_nxt.tmr_cnt = s_r.pri_rld;
        s_nxt.irq     = 1'b1;
      end
    end

    // Register writes in the data phase; they win over counting
    if (s_r.wr_q)
    begin
      unique case (s_r.addr_q)
        `IDX_TIMER_CONTROL:
        begin
          // Halt wins over a run request in the same write
          if (wd[`BIT_FORCED_HALT])
          begin
            s_nxt.run      = 1'b0;
            s_nxt.active   = 1'b0;
            s_nxt.pre_rld  = `RST_RELOAD;
            s_nxt.pre_cnt  = `RST_RELOAD;
            s_nxt.sec_rld  = `RST_RELOAD;
            s_nxt.sec_use  = `RST_RELOAD;
            s_nxt.pri_rld  = `RST_RELOAD;
            s_nxt.pri_use  = `RST_RELOAD;
            s_nxt.tmr_cnt  = `RST_RELOAD;
            s_nxt.pre_pend = 1'b0;
            s_nxt.tmr_pend = 1'b0;
            s_nxt.pri_new  = 1'b0;
            s_nxt.phase    = PH_PRIMARY;
            s_nxt.irq      = 1'b0;
          end
          else
          begin
            s_nxt.run    = wd[`BIT_RUN_REQUEST];
            s_nxt.active = wd[`BIT_RUN_REQUEST];
            if (wd[`BIT_RUN_REQUEST] && !s_r.active)
            begin
              s_nxt.phase    = PH_PRIMARY;
              s_nxt.osel_act = s_r.ioc[`BIT_OUTPUT_SOURCE];
              if (wave)
              begin
                s_nxt.pri_use = s_r.pri_rld;
                s_nxt.sec_use = s_r.sec_rld;
                s_nxt.tmr_cnt = s_r.pri_rld;
                s_nxt.pri_new = 1'b0;
              end
            end
          end
        end
        `IDX_ONESHOT_CONTROL:
        begin
          s_nxt.ioc = s_r.ioc;
        end
        `IDX_OUTPUT_CONTROL:
        begin
          s_nxt.ioc = wd[3:0];
        end
        `IDX_TIMER_MODE_CFG:
        begin
          s_nxt.mode = mode_t'(wd[`LSB_MODE +: 2]);
          s_nxt.wtgt = wd[`BIT_WRITE_TARGET];
          s_nxt.src  = src_t'(wd[`LSB_SOURCE_SELECT +: 2]);
          s_nxt.cut  = wd[`BIT_SOURCE_CUTOFF];
        end
        `IDX_PRESCALER_RELOAD:
        begin
          s_nxt.pre_rld = wd;
          if (!s_r.active)
          begin
            s_nxt.pre_cnt  = wd;
            s_nxt.pre_pend = 1'b0;
          end
          else if (!wave && !s_r.wtgt)
          begin
            s_nxt.pre_pend = 1'b1;
          end
        end
        `IDX_SECONDARY_RELOAD:
        begin
          s_nxt.sec_rld = wd;
          if (!s_r.active)
          begin
            s_nxt.sec_use = wd;
          end
        end
        `IDX_PRIMARY_RELOAD:
        begin
          s_nxt.pri_rld = wd;
          if (!s_r.active)
          begin
            s_nxt.tmr_cnt  = wd;
            s_nxt.pri_use  = wd;
            s_nxt.tmr_pend = 1'b0;
          end
          else if (wave)
          begin
            s_nxt.pri_new = 1'b1;
          end
          else if (!s_r.wtgt)
          begin
            s_nxt.tmr_pend = 1'b1;
          end
        end
        default:
        begin
          s_nxt.ioc = s_r.ioc;
        end
      endcase
    end

    // Pin level from phase, polarity and output source
    // Stopped level equals the polarity bit, the secondary level
    if (!s_nxt.active)
    begin
      s_nxt.pin = s_nxt.ioc[`BIT_LEVEL_POLARITY];
    end
    else if (s_nxt.osel_act)
    begin
      s_nxt.pin = shared_port_latch;
    end
    else
    begin
      s_nxt.pin = (s_nxt.phase == PH_PRIMARY) ^
                  s_nxt.ioc[`BIT_LEVEL_POLARITY];
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_r <= RESET_STATE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero-wait slave: every transfer ends with its data phase
  assign hrdata        = {24'h00_0000, s_r.rdata};
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign pulse_out_pin = s_r.pin;
  assign pulse_out_oe  = (s_r.mode == MODE_WAVE);
  assign timer_irq     = s_r.irq;

endmodule

`default_nettype wire

/* core/timer_rb_pkg.sv */
/*
  Types of the prescaled reload timer: modes, source codes, phase
  and the packed state record. Assumes the _regs header for numbers.
*/
package timer_rb_pkg;

  typedef enum logic [1:0] {
    MODE_TIMER   = 2'h0,
    MODE_WAVE    = 2'h1,
    MODE_ONESHOT = 2'h2,
    MODE_WAIT    = 2'h3
  } mode_t;

  typedef enum logic [1:0] {
    SRC_UNDIVIDED = 2'h0,
    SRC_EIGHTH    = 2'h1,
    SRC_COMPANION = 2'h2,
    SRC_HALF      = 2'h3
  } src_t;

  typedef enum logic {
    PH_PRIMARY,
    PH_SECONDARY
  } phase_t;

  typedef struct packed {
    logic        wr_q;
    logic [9:0]  addr_q;
    logic [7:0]  rdata;
    logic [2:0]  div;
    logic        run;
    logic        active;
    mode_t       mode;
    logic        wtgt;
    src_t        src;
    logic        cut;
    logic [3:0]  ioc;
    logic [7:0]  pre_rld;
    logic [7:0]  pre_cnt;
    logic [7:0]  sec_rld;
    logic [7:0]  pri_rld;
    logic [7:0]  tmr_cnt;
    logic        pre_pend;
    logic        tmr_pend;
    phase_t      phase;
    logic [7:0]  pri_use;
    logic [7:0]  sec_use;
    logic        pri_new;
    logic        osel_act;
    logic        pin;
    logic        irq;
  } state_t;

endpackage

/* core/timer_rb_regs.svh */
/*
  Register indices, field positions and reset values of the
  prescaled reload timer. Assumes byte address = index * 4 on the bus.
*/
`ifndef TIMER_RB_REGS_SVH
`define TIMER_RB_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_TIMER_CONTROL    10'h108
`define IDX_ONESHOT_CONTROL  10'h109
`define IDX_OUTPUT_CONTROL   10'h10A
`define IDX_TIMER_MODE_CFG   10'h10B
`define IDX_PRESCALER_RELOAD 10'h10C
`define IDX_SECONDARY_RELOAD 10'h10D
`define IDX_PRIMARY_RELOAD   10'h10E

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_RUN_REQUEST      0
`define BIT_COUNT_ACTIVE     1
`define BIT_FORCED_HALT      2
`define BIT_LEVEL_POLARITY   0
`define BIT_OUTPUT_SOURCE    1
`define BIT_WRITE_TARGET     3
`define BIT_SOURCE_CUTOFF    7
`define LSB_SOURCE_SELECT    4
`define LSB_MODE             0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_RELOAD           8'hFF
`define RST_CONTROL          8'h00
`define RST_DIVIDER          3'h7

`endif

/* tb/test_prescaled_reload_timer_waveform.sv */
/* Self-checking bench for the reload timer.
   Assumes zero-wait slave; drives bus and companion pulse itself. */
`include "timer_rb_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module test_prescaled_reload_timer_waveform;
  logic        hclk = 0;
  logic        hresetn;
  logic        hsel = 0;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic        hwrite = 0;
  logic [31:0] hwdata = 0;
  logic        comp_uf = 0;
  logic        comp_en = 0;
  logic [1:0]  comp_cnt = 0;
  logic        port_latch = 1'b1;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         pin;
  wire         oe;
  wire         irq;
  logic [7:0]  v;
  int          n;
  int          err_count = 0;
  int          n_compared = 0;
  logic [1:0]  src_code [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
  int          src_mult [4] = '{1, 2, 8, 3};

  // ----------------------------------------------------------------
  // Clock, companion pulses and device
  // ----------------------------------------------------------------
  always #20 hclk = ~hclk;

  // Companion underflow every third cycle once enabled
  always @(posedge hclk)
  begin
    comp_cnt <= (comp_cnt == 2'h2) ? 2'h0 : comp_cnt + 2'h1;
    comp_uf  <= comp_en && (comp_cnt == 2'h2);
  end

  prescaled_reload_timer_waveform u_prescaled_reload_timer_waveform
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .companion_uf(comp_uf), .shared_port_latch(port_latch),
    .pulse_out_pin(pin), .pulse_out_oe(oe), .timer_irq(irq)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single AHB-Lite transfer; read byte lands in v
  task automatic bus(input logic [9:0] idx, input logic w, input logic [7:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata[7:0];
    @(negedge hclk);
  endtask

  // Cycles from one irq to the next
  task automatic gap(output int c);
    int k;
    k = 0;
    do @(negedge hclk); while (irq !== 1'b1 && ++k < 3000);
    c = 1;
    do @(negedge hclk); while (irq !== 1'b1 && ++c < 3000);
  endtask

  // Length of the next run of pin at level l
  task automatic len(input logic l, output int c);
    int k;
    k = 0;
    c = 0;
    while (pin !== l && k++ < 300) @(negedge hclk);
    while (pin === l && c < 300)
    begin
      @(negedge hclk);
      c++;
    end
  endtask

  task automatic complete_run;
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(`IDX_PRIMARY_RELOAD, 0, 0);   chk("primary rst", v, 8'hFF);
    bus(`IDX_PRESCALER_RELOAD, 0, 0); chk("presc rst", v, 8'hFF);
    bus(`IDX_OUTPUT_CONTROL, 0, 0);   chk("outctl rst", v, 8'h00);
    bus(10'h100, 0, 0);               chk("unmapped", v, 8'h00);
    chk("oe timer", oe, 1'b1 ^ 1'b1);
    // Timer mode n=1 m=2: six ticks per underflow, each source
    bus(`IDX_PRESCALER_RELOAD, 1, 8'h01);
    bus(`IDX_PRIMARY_RELOAD, 1, 8'h02);
    bus(`IDX_PRIMARY_RELOAD, 0, 0);   chk("loaded", v, 8'h02);
    comp_en <= 1'b1;
    foreach (src_code[i])
    begin
      bus(`IDX_TIMER_MODE_CFG, 1, {2'b00, src_code[i], 4'h0});
      bus(`IDX_TIMER_CONTROL, 1, 8'h01);
      bus(`IDX_TIMER_CONTROL, 0, 0); chk("active", v, 8'h03);
      gap(n);
      gap(n); chk("period", n, 6 * src_mult[i]);
      bus(`IDX_TIMER_CONTROL, 1, 8'h00);
    end
    n = 0;
    repeat (60) @(negedge hclk) n += irq;
    chk("idle irq", n, 0);
    // Cutoff bit blocks every tick while running
    bus(`IDX_TIMER_MODE_CFG, 1, 8'h80);
    bus(`IDX_TIMER_CONTROL, 1, 8'h01);
    n = 0;
    repeat (60) @(negedge hclk) n += irq;
    chk("cutoff irq", n, 0);
    bus(`IDX_TIMER_CONTROL, 1, 8'h00);
    // Write target 1 then 0 while running
    bus(`IDX_TIMER_MODE_CFG, 1, 8'h08);
    bus(`IDX_TIMER_CONTROL, 1, 8'h01);
    bus(`IDX_PRIMARY_RELOAD, 1, 8'h04);
    gap(n);
    gap(n); chk("reload only", n, 10);
    bus(`IDX_TIMER_CONTROL, 1, 8'h00);
    bus(`IDX_TIMER_MODE_CFG, 1, 8'h00);
    bus(`IDX_TIMER_CONTROL, 1, 8'h01);
    bus(`IDX_PRIMARY_RELOAD, 1, 8'hC8);
    repeat (4) @(negedge hclk);
    bus(`IDX_PRIMARY_RELOAD, 0, 0); chk("live", v > 8'hBE && v <= 8'hC8, 1);
    // Forced halt clears reloads and run
    bus(`IDX_TIMER_CONTROL, 1, 8'h04);
    bus(`IDX_PRIMARY_RELOAD, 0, 0); chk("halt pri", v, 8'hFF);
    bus(`IDX_TIMER_CONTROL, 0, 0);  chk("halt ctl", v, 8'h00);
    // Waveform n=0 m=4 p=2, polarity 0
    bus(`IDX_TIMER_MODE_CFG, 1, 8'h09);
    bus(`IDX_PRESCALER_RELOAD, 1, 8'h00);
    bus(`IDX_SECONDARY_RELOAD, 1, 8'h02);
    bus(`IDX_PRIMARY_RELOAD, 1, 8'h04);
    chk("stop lvl0", pin, 1'b0);
    chk("oe wave", oe, 1'b1);
    bus(`IDX_TIMER_CONTROL, 1, 8'h01);
    len(1'b1, n); chk("first pri", n, 5);
    len(1'b0, n); chk("sec", n, 3);
    chk("irq edge", irq, 1'b1);
    // Secondary first, then primary, while running
    bus(`IDX_SECONDARY_RELOAD, 1, 8'h06);
    bus(`IDX_PRIMARY_RELOAD, 1, 8'h01);
    gap(n);
    gap(n); chk("wave period", n, 9);
    len(1'b1, n); chk("new pri", n, 2);
    len(1'b0, n); chk("new sec", n, 7);
    // Polarity 1 inverts all levels
    bus(`IDX_TIMER_CONTROL, 1, 8'h00);
    bus(`IDX_OUTPUT_CONTROL, 1, 8'h01);
    repeat (2) @(negedge hclk);
    chk("stop lvl1", pin, 1'b1);
    bus(`IDX_TIMER_CONTROL, 1, 8'h01);
    len(1'b0, n); chk("pri pol1", n, 2);
    len(1'b1, n); chk("sec pol1", n, 7);
    // Output source picks the port latch from the next primary interval
    bus(`IDX_OUTPUT_CONTROL, 1, 8'h03);
    gap(n);
    chk("latch hi", pin, 1'b1);
    @(posedge hclk) port_latch <= 1'b0;
    repeat (2) @(negedge hclk);
    chk("latch lo", pin, 1'b0);
    complete_run();
  end

  // Watchdog against a hung wait
  initial
  begin
    repeat (40000) @(posedge hclk);
    err_count++;
    complete_run();
  end
endmodule

`default_nettype wire

/* tb/timer_rb_props.sv */
/* Port checker for the reload timer.
   Assumes binding to the top module, one hclk domain. */
`include "timer_rb_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module timer_rb_props
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        pulse_out_pin,
  input wire logic        pulse_out_oe,
  input wire logic        timer_irq
);
  // ----------------------------------------------------------------
  // Bus decode and relations
  // ----------------------------------------------------------------
  wire       rd_go = hsel && htrans[1] && hready && !hwrite;
  wire [9:0] idx   = haddr[11:2];

  ready_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout) else $error("hreadyout dropped");
  okay_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !hresp) else $error("hresp not OKAY");
  rdata_upper_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:8] == 24'h00_0000) else $error("upper read lanes set");
  rdata_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_go |=> $stable(hrdata)) else $error("hrdata moved without read");
  sec_read_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_go && idx == `IDX_SECONDARY_RELOAD |=> hrdata == 32'h0000_0000)
    else $error("secondary read not zero");
  halt_bit_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_go && idx == `IDX_TIMER_CONTROL |=> !hrdata[`BIT_FORCED_HALT])
    else $error("halt bit read as one");
  oneshot_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_go && idx == `IDX_ONESHOT_CONTROL |=> hrdata == 32'h0000_0000)
    else $error("oneshot read not zero");
  oe_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(pulse_out_oe) |-> $past(hsel && htrans[1] && hwrite, 2))
    else $error("pin enable moved without write");
  wave_irq_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    timer_irq && pulse_out_oe |=> !timer_irq) else $error("irq too long");
  reset_quiet_a: assert property (@(posedge hclk)
    !hresetn |-> hrdata == 32'h0000_0000 && !timer_irq && !pulse_out_oe)
    else $error("outputs active in reset");
endmodule

bind prescaled_reload_timer_waveform timer_rb_props u_timer_rb_props
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .pulse_out_pin(pulse_out_pin),
  .pulse_out_oe(pulse_out_oe), .timer_irq(timer_irq)
);

`default_nettype wire
